// >>> core/irqfs_defines.svh
/*
  Register indices, field positions and reset values of the interrupt and
  FIFO status register group. Assumes byte address = index * 4 on APB.
*/
`ifndef IRQFS_DEFINES_SVH
`define IRQFS_DEFINES_SVH

// ==========================================
// register indices (byte address is index * 4)
`define IRQFS_IDX_CFG 10'h010
`define IRQFS_IDX_MASK_TIM 10'h015
`define IRQFS_IDX_MASK_ERR 10'h016
`define IRQFS_IDX_MAIN 10'h017
`define IRQFS_IDX_TIM 10'h018
`define IRQFS_IDX_ERR 10'h019
`define IRQFS_IDX_FIFO1 10'h01A
`define IRQFS_IDX_FIFO2 10'h01B

// ==========================================
// timer/nfc event register fields
`define IRQFS_TIM_DCT 7
`define IRQFS_TIM_NRE 6
`define IRQFS_TIM_GPE 5
`define IRQFS_TIM_EON 4
`define IRQFS_TIM_EOF 3
`define IRQFS_TIM_CAC 2
`define IRQFS_TIM_CAT 1
`define IRQFS_TIM_NFCT 0

// ==========================================
// error/wake-up event register fields
`define IRQFS_ERR_CRC 7
`define IRQFS_ERR_PAR 6
`define IRQFS_ERR_SOFT 5
`define IRQFS_ERR_HARD 4
`define IRQFS_ERR_WT 3
`define IRQFS_ERR_WAM 2
`define IRQFS_ERR_WPH 1
`define IRQFS_ERR_WCAP 0

// ==========================================
// fifo condition register fields, main summary bits, config bits
`define IRQFS_F2_UNF 6
`define IRQFS_F2_OVR 5
`define IRQFS_F2_NCP 4
`define IRQFS_F2_LB_HI 3
`define IRQFS_F2_LB_LO 1
`define IRQFS_F2_NP 0
`define IRQFS_MAIN_TIM 1
`define IRQFS_MAIN_ERR 0
`define IRQFS_CFG_WT_EVERY 0

// ==========================================
// reset values and limits
`define IRQFS_RST8 8'h00
`define IRQFS_RST7 7'h00
`define IRQFS_RST3 3'h0
`define IRQFS_ALL8 8'hFF
`define IRQFS_RST32 32'h0000_0000

`endif

// >>> core/irqfs_pkg.sv
/*
  Types of the interrupt and FIFO status register group.
  Assumes nothing beyond the defines header.
*/
package irqfs_pkg;

  // ==========================================
  // complete state of the register group
  typedef struct packed {
    logic [7:0] tim;
    logic [7:0] err;
    logic [7:0] mask_tim;
    logic [7:0] mask_err;
    logic [7:0] cfg;
    logic [6:0] cnt;
    logic unf;
    logic ovr;
    logic ncp;
    logic [2:0] lbits;
    logic np;
    logic irq;
    logic [31:0] prdata;
  } irqfs_state_t;

endpackage

// >>> core/irqfs_regs.sv
/*
  Interrupt source and FIFO status register group with APB slave,
  event masks, summary bits and one interrupt output.
  Assumes event inputs are one-cycle pulses and FIFO status inputs are
  levels, all from logic on mclk_i; set_default_i and fifo_clear_i are
  one-cycle pulses from the direct command decoder.
*/
`timescale 1ns/10ps
`include "irqfs_defines.svh"

// Summary of operation
// - flag command done and timer expiries
// - flag external field rising and falling
// - flag field found during collision avoidance
// - flag guard time elapsed after field on
// - flag initiator bit rate recognized as target
// - event registers zero on reset, set default
// - timer event register clears after read
// - error event register clears after read
// - flag crc, parity and hard framing errors
// - flag soft framing error
// - flag wake timeout when every-timeout option set
// - flag amplitude, phase, capacitance deltas
// - report seven bit unread byte count
// - fifo registers zero on reset, default, clear
// - flag fifo underflow and overflow
// - report incomplete last byte and bit count
// - flag missing parity, counts as framing error
// - empty fifo reads zero count, incomplete flag and bit count
// - summary bits clear via detailed read, set default or mask, never via own read
// - set mask bit blocks its interrupt
module irqfs_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic set_default_i,
  input wire logic fifo_clear_i,
  input wire logic cmd_done_evt_i,
  input wire logic noresp_timer_evt_i,
  input wire logic gp_timer_evt_i,
  input wire logic field_on_evt_i,
  input wire logic field_off_evt_i,
  input wire logic ca_collision_evt_i,
  input wire logic ca_guard_done_evt_i,
  input wire logic target_rate_evt_i,
  input wire logic crc_err_evt_i,
  input wire logic parity_err_evt_i,
  input wire logic soft_framing_evt_i,
  input wire logic hard_framing_evt_i,
  input wire logic wake_timer_evt_i,
  input wire logic ampl_delta_evt_i,
  input wire logic phase_delta_evt_i,
  input wire logic cap_delta_evt_i,
  input wire logic [6:0] fifo_count_i,
  input wire logic underflow_evt_i,
  input wire logic overflow_evt_i,
  input wire logic last_byte_incomplete_i,
  input wire logic [2:0] last_byte_bits_i,
  input wire logic last_byte_parity_missing_i,
  output logic irq_o,
  output logic wake_every_timeout_o
);
  import irqfs_pkg::*;

  irqfs_state_t st_r;
  irqfs_state_t st_nxt;

  // ==========================================
  // bus decode
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[11:2] == idx);
  endfunction

  logic setup_ph;
  logic acc_done;
  logic rd_tim;
  logic rd_err;
  logic mapped;
  logic [7:0] tim_evt;
  logic [7:0] err_evt;
  logic [7:0] rd8;

  // setup captures read data, so the access phase never waits
  assign setup_ph = psel_i && !penable_i;
  assign acc_done = psel_i && penable_i;
  assign pready_o = acc_done;
  assign rd_tim = acc_done && !pwrite_i && hit(paddr_i, `IRQFS_IDX_TIM);
  assign rd_err = acc_done && !pwrite_i && hit(paddr_i, `IRQFS_IDX_ERR);
  assign mapped = hit(paddr_i, `IRQFS_IDX_CFG) || hit(paddr_i, `IRQFS_IDX_MASK_TIM)
    || hit(paddr_i, `IRQFS_IDX_MASK_ERR) || hit(paddr_i, `IRQFS_IDX_MAIN)
    || hit(paddr_i, `IRQFS_IDX_TIM) || hit(paddr_i, `IRQFS_IDX_ERR)
    || hit(paddr_i, `IRQFS_IDX_FIFO1) || hit(paddr_i, `IRQFS_IDX_FIFO2);
  assign pslverr_o = acc_done && !mapped;

  // ==========================================
  // event vectors in register bit order
  always_comb
  begin
    tim_evt = `IRQFS_RST8;
    tim_evt[`IRQFS_TIM_DCT] = cmd_done_evt_i;
    tim_evt[`IRQFS_TIM_NRE] = noresp_timer_evt_i;
    tim_evt[`IRQFS_TIM_GPE] = gp_timer_evt_i;
    tim_evt[`IRQFS_TIM_EON] = field_on_evt_i;
    tim_evt[`IRQFS_TIM_EOF] = field_off_evt_i;
    tim_evt[`IRQFS_TIM_CAC] = ca_collision_evt_i;
    tim_evt[`IRQFS_TIM_CAT] = ca_guard_done_evt_i;
    tim_evt[`IRQFS_TIM_NFCT] = target_rate_evt_i;
    err_evt = `IRQFS_RST8;
    err_evt[`IRQFS_ERR_CRC] = crc_err_evt_i;
    err_evt[`IRQFS_ERR_PAR] = parity_err_evt_i;
    // missing parity on a new last byte also reports as a soft framing error
    err_evt[`IRQFS_ERR_SOFT] = soft_framing_evt_i
      || (last_byte_parity_missing_i && !st_r.np);
    err_evt[`IRQFS_ERR_HARD] = hard_framing_evt_i;
    // one-shot mode keeps the wake timer quiet here
    err_evt[`IRQFS_ERR_WT] = wake_timer_evt_i && st_r.cfg[`IRQFS_CFG_WT_EVERY];
    err_evt[`IRQFS_ERR_WAM] = ampl_delta_evt_i;
    err_evt[`IRQFS_ERR_WPH] = phase_delta_evt_i;
    err_evt[`IRQFS_ERR_WCAP] = cap_delta_evt_i;
  end

  // ==========================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // clear-on-read first, then events, so a same-cycle event survives
    if (rd_tim)
      st_nxt.tim = `IRQFS_RST8;
    if (rd_err)
      st_nxt.err = `IRQFS_RST8;
    if (set_default_i)
    begin
      st_nxt.tim = `IRQFS_RST8;
      st_nxt.err = `IRQFS_RST8;
      st_nxt.mask_tim = `IRQFS_RST8;
      st_nxt.mask_err = `IRQFS_RST8;
      st_nxt.cfg = `IRQFS_RST8;
    end
    st_nxt.tim = st_nxt.tim | tim_evt;
    st_nxt.err = st_nxt.err | err_evt;

    // fifo status follows the datapath, sticky flags hold until clear
    st_nxt.cnt = fifo_count_i;
    st_nxt.unf = st_r.unf || underflow_evt_i;
    st_nxt.ovr = st_r.ovr || overflow_evt_i;
    st_nxt.ncp = last_byte_incomplete_i;
    st_nxt.lbits = last_byte_incomplete_i ? last_byte_bits_i : `IRQFS_RST3;
    st_nxt.np = last_byte_parity_missing_i;
    if (fifo_count_i == `IRQFS_RST7)
    begin
      st_nxt.ncp = 1'b0;
      st_nxt.lbits = `IRQFS_RST3;
    end
    if (set_default_i || fifo_clear_i)
    begin
      st_nxt.cnt = `IRQFS_RST7;
      // a fault in the clear cycle itself still shows afterwards
      st_nxt.unf = underflow_evt_i;
      st_nxt.ovr = overflow_evt_i;
      st_nxt.ncp = 1'b0;
      st_nxt.lbits = `IRQFS_RST3;
      st_nxt.np = 1'b0;
    end

    // software writes to the masks and configuration
    if (acc_done && pwrite_i && !set_default_i)
    begin
      if (hit(paddr_i, `IRQFS_IDX_MASK_TIM))
        st_nxt.mask_tim = pwdata_i[7:0];
      if (hit(paddr_i, `IRQFS_IDX_MASK_ERR))
        st_nxt.mask_err = pwdata_i[7:0];
      if (hit(paddr_i, `IRQFS_IDX_CFG))
        st_nxt.cfg = pwdata_i[7:0];
    end

    // masked events never reach the pin
    st_nxt.irq = |(st_nxt.tim & ~st_nxt.mask_tim)
      || |(st_nxt.err & ~st_nxt.mask_err);

    // read data taken from the next state so nothing set at setup is lost
    rd8 = `IRQFS_RST8;
    if (hit(paddr_i, `IRQFS_IDX_CFG))
      rd8 = st_nxt.cfg;
    if (hit(paddr_i, `IRQFS_IDX_MASK_TIM))
      rd8 = st_nxt.mask_tim;
    if (hit(paddr_i, `IRQFS_IDX_MASK_ERR))
      rd8 = st_nxt.mask_err;
    if (hit(paddr_i, `IRQFS_IDX_MAIN))
    begin
      // summary bits derive from the detailed registers and masks, never cleared by this read
      rd8[`IRQFS_MAIN_TIM] = |(st_nxt.tim & ~st_nxt.mask_tim);
      rd8[`IRQFS_MAIN_ERR] = |(st_nxt.err & ~st_nxt.mask_err);
    end
    if (hit(paddr_i, `IRQFS_IDX_TIM))
      rd8 = st_nxt.tim;
    if (hit(paddr_i, `IRQFS_IDX_ERR))
      rd8 = st_nxt.err;
    if (hit(paddr_i, `IRQFS_IDX_FIFO1))
      rd8 = {1'b0, st_nxt.cnt};
    if (hit(paddr_i, `IRQFS_IDX_FIFO2))
    begin
      rd8[`IRQFS_F2_UNF] = st_nxt.unf;
      rd8[`IRQFS_F2_OVR] = st_nxt.ovr;
      rd8[`IRQFS_F2_NCP] = st_nxt.ncp;
      rd8[`IRQFS_F2_LB_HI:`IRQFS_F2_LB_LO] = st_nxt.lbits;
      rd8[`IRQFS_F2_NP] = st_nxt.np;
    end
    if (setup_ph && !pwrite_i)
      st_nxt.prdata = {24'h00_0000, rd8};
  end

  // ==========================================
  // state register
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign prdata_o = st_r.prdata;
  assign irq_o = st_r.irq;
  assign wake_every_timeout_o = st_r.cfg[`IRQFS_CFG_WT_EVERY];

  // ==========================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic quiet_tim;
  logic quiet_err;
  assign quiet_tim = (tim_evt == `IRQFS_RST8);
  assign quiet_err = (err_evt == `IRQFS_RST8);

  sequence s_tim_read;
    setup_ph && !pwrite_i && hit(paddr_i, `IRQFS_IDX_TIM) ##1 rd_tim;
  endsequence

  property p_dct_sets;
    cmd_done_evt_i |=> st_r.tim[`IRQFS_TIM_DCT];
  endproperty
  a_dct_sets: assert property (p_dct_sets) else $error("command done not flagged");

  property p_field_on;
    field_on_evt_i && !field_off_evt_i |=> st_r.tim[`IRQFS_TIM_EON];
  endproperty
  a_field_on: assert property (p_field_on) else $error("field on not flagged");

  property p_default_zero;
    set_default_i && quiet_tim && quiet_err |=> st_r.tim == `IRQFS_RST8
      && st_r.err == `IRQFS_RST8;
  endproperty
  a_default_zero: assert property (p_default_zero) else $error("set default left flags");

  property p_tim_cor;
    s_tim_read ##0 quiet_tim |=> st_r.tim == `IRQFS_RST8;
  endproperty
  a_tim_cor: assert property (p_tim_cor) else $error("timer flags not cleared on read");

  property p_read_returns;
    s_tim_read |-> prdata_o[7:0] == st_r.tim;
  endproperty
  a_read_returns: assert property (p_read_returns) else $error("read data mismatch");

  property p_evt_wins;
    rd_tim && !quiet_tim |=> (st_r.tim & $past(tim_evt)) == $past(tim_evt);
  endproperty
  a_evt_wins: assert property (p_evt_wins) else $error("event lost at read");

  property p_wt_gated;
    wake_timer_evt_i && !st_r.cfg[`IRQFS_CFG_WT_EVERY] && !st_r.err[`IRQFS_ERR_WT]
      |=> !st_r.err[`IRQFS_ERR_WT];
  endproperty
  a_wt_gated: assert property (p_wt_gated) else $error("wake flag set in one-shot mode");

  property p_count;
    !set_default_i && !fifo_clear_i |=> st_r.cnt == $past(fifo_count_i);
  endproperty
  a_count: assert property (p_count) else $error("byte count not tracking");

  property p_empty_fields;
    st_r.cnt == `IRQFS_RST7 |-> !st_r.ncp && st_r.lbits == `IRQFS_RST3;
  endproperty
  a_empty_fields: assert property (p_empty_fields) else $error("empty fifo shows fields");

  property p_unf;
    underflow_evt_i && !fifo_clear_i && !set_default_i |=> st_r.unf
      ##1 (st_r.unf || $past(fifo_clear_i) || $past(set_default_i));
  endproperty
  a_unf: assert property (p_unf) else $error("underflow not held");

  property p_mask_all;
    st_r.mask_tim == `IRQFS_ALL8 && st_r.mask_err == `IRQFS_ALL8 && !acc_done
      && !set_default_i |=> !irq_o;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked event raised irq");

  // two-step reads of the error and the summary register
  sequence s_err_read;
    setup_ph && !pwrite_i && hit(paddr_i, `IRQFS_IDX_ERR) ##1 rd_err;
  endsequence

  sequence s_main_read;
    setup_ph && !pwrite_i && hit(paddr_i, `IRQFS_IDX_MAIN)
      ##1 acc_done && !pwrite_i && hit(paddr_i, `IRQFS_IDX_MAIN);
  endsequence

  property p_field_off;
    field_off_evt_i |=> st_r.tim[`IRQFS_TIM_EOF];
  endproperty
  a_field_off: assert property (p_field_off) else $error("field off not flagged");

  property p_ca_collision;
    ca_collision_evt_i |=> st_r.tim[`IRQFS_TIM_CAC];
  endproperty
  a_ca_collision: assert property (p_ca_collision) else $error("collision not flagged");

  property p_guard_done;
    ca_guard_done_evt_i |=> st_r.tim[`IRQFS_TIM_CAT];
  endproperty
  a_guard_done: assert property (p_guard_done) else $error("guard time not flagged");

  property p_target_rate;
    target_rate_evt_i |=> st_r.tim[`IRQFS_TIM_NFCT];
  endproperty
  a_target_rate: assert property (p_target_rate) else $error("bit rate not flagged");

  property p_err_cor;
    s_err_read ##0 quiet_err |=> st_r.err == `IRQFS_RST8;
  endproperty
  a_err_cor: assert property (p_err_cor) else $error("error flags not cleared on read");

  property p_err_returns;
    s_err_read |-> prdata_o[7:0] == st_r.err;
  endproperty
  a_err_returns: assert property (p_err_returns) else $error("error read data mismatch");

  property p_crc_sets;
    crc_err_evt_i |=> st_r.err[`IRQFS_ERR_CRC];
  endproperty
  a_crc_sets: assert property (p_crc_sets) else $error("crc error not flagged");

  property p_soft_sets;
    soft_framing_evt_i |=> st_r.err[`IRQFS_ERR_SOFT];
  endproperty
  a_soft_sets: assert property (p_soft_sets) else $error("soft framing not flagged");

  property p_wt_every;
    wake_timer_evt_i && st_r.cfg[`IRQFS_CFG_WT_EVERY] |=> st_r.err[`IRQFS_ERR_WT];
  endproperty
  a_wt_every: assert property (p_wt_every) else $error("wake timeout not flagged");

  // each measurement source lands in its own bit
  property p_deltas;
    ampl_delta_evt_i || phase_delta_evt_i || cap_delta_evt_i
      |=> (st_r.err[`IRQFS_ERR_WAM] || !$past(ampl_delta_evt_i))
      && (st_r.err[`IRQFS_ERR_WPH] || !$past(phase_delta_evt_i))
      && (st_r.err[`IRQFS_ERR_WCAP] || !$past(cap_delta_evt_i));
  endproperty
  a_deltas: assert property (p_deltas) else $error("measurement delta not flagged");

  property p_clear_zero;
    fifo_clear_i && !underflow_evt_i && !overflow_evt_i |=> st_r.cnt == `IRQFS_RST7
      && !st_r.unf && !st_r.ovr && !st_r.ncp && st_r.lbits == `IRQFS_RST3 && !st_r.np;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear left fifo status");

  property p_lbits;
    last_byte_incomplete_i && fifo_count_i != `IRQFS_RST7 && !fifo_clear_i && !set_default_i
      |=> st_r.ncp && st_r.lbits == $past(last_byte_bits_i);
  endproperty
  a_lbits: assert property (p_lbits) else $error("last byte bits not shown");

  property p_np_framing;
    last_byte_parity_missing_i && !st_r.np && !fifo_clear_i && !set_default_i
      |=> st_r.np && st_r.err[`IRQFS_ERR_SOFT];
  endproperty
  a_np_framing: assert property (p_np_framing) else $error("missing parity not flagged");

  // reading the summary must never drop a detailed flag
  property p_main_keeps;
    s_main_read ##0 !set_default_i |=> (st_r.tim & $past(st_r.tim)) == $past(st_r.tim)
      && (st_r.err & $past(st_r.err)) == $past(st_r.err);
  endproperty
  a_main_keeps: assert property (p_main_keeps) else $error("summary read cleared flags");

endmodule

// >>> sim/irqfs_host.sv
/*
  Host model: APB master that reads and writes the status register group.
  Assumes each task call starts just after a rising edge of mclk_i.
*/
`timescale 1ns/10ps
module irqfs_host (
  input wire logic mclk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  // ==========================================
  // idle bus at time zero
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end

  // ==========================================
  // one transfer, held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
    output logic [7:0] rd, output logic err);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= {idx, 2'b00};  // one word per register
    pwdata_o <= {24'h000000, wd};
    @(posedge mclk_i);
    penable_o <= 1'b1;
    @(posedge mclk_i);
    while (pready_i !== 1'b1)
    begin
      @(posedge mclk_i);
    end
    rd = prdata_i[7:0];
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // released lines must not look like stale valid values
    paddr_o <= ~paddr_o;
    pwdata_o <= ~pwdata_o;
  endtask
endmodule

// >>> sim/irq_and_fifo_status_regs_tb.sv
/*
  Self-checking bench of the interrupt and FIFO status register group.
  Assumes the design, its defines header and the host model are compiled.
*/
`timescale 1ns/10ps
`include "irqfs_defines.svh"
module irq_and_fifo_status_regs_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq, wake_every, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic set_default = 1'b0;
  logic fifo_clear = 1'b0;
  logic [7:0] tev = 8'h00;
  logic [7:0] eev = 8'h00;
  logic unf = 1'b0;
  logic ovr = 1'b0;
  logic ncp = 1'b0;
  logic np = 1'b0;
  logic [6:0] cnt = 7'h00;
  logic [2:0] lbits = 3'h0;
  logic [7:0] got;
  int num_errors = 0;
  int total_checks = 0;

  // ==========================================
  // design and host model
  irqfs_regs irqfs_regs_inst (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .set_default_i(set_default), .fifo_clear_i(fifo_clear),
    .cmd_done_evt_i(tev[7]), .noresp_timer_evt_i(tev[6]), .gp_timer_evt_i(tev[5]),
    .field_on_evt_i(tev[4]), .field_off_evt_i(tev[3]), .ca_collision_evt_i(tev[2]),
    .ca_guard_done_evt_i(tev[1]), .target_rate_evt_i(tev[0]),
    .crc_err_evt_i(eev[7]), .parity_err_evt_i(eev[6]), .soft_framing_evt_i(eev[5]),
    .hard_framing_evt_i(eev[4]), .wake_timer_evt_i(eev[3]), .ampl_delta_evt_i(eev[2]),
    .phase_delta_evt_i(eev[1]), .cap_delta_evt_i(eev[0]), .fifo_count_i(cnt),
    .underflow_evt_i(unf), .overflow_evt_i(ovr), .last_byte_incomplete_i(ncp),
    .last_byte_bits_i(lbits), .last_byte_parity_missing_i(np), .irq_o(irq),
    .wake_every_timeout_o(wake_every));
  irqfs_host irqfs_host_inst (.mclk_i(mclk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  // ==========================================
  // helpers
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // spare edge after each transfer keeps drivers one assignment per step
  task automatic acc(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    irqfs_host_inst.xfer(wr, idx, wd, got, err);
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    acc(1'b0, idx, 8'h00);
    check(got, e);
  endtask

  task automatic pulse(input logic [7:0] t, input logic [7:0] e);
    tev <= t;
    eev <= e;
    @(posedge mclk_i);
    tev <= 8'h00;
    eev <= 8'h00;
    @(posedge mclk_i);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // clock and watchdog
  always #5 mclk_i = ~mclk_i;

  initial
  begin
    #200000;
    num_errors++;
    end_of_test();
  end

  // ==========================================
  // test sequence
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(`IRQFS_IDX_TIM, 8'h00);
    rd(`IRQFS_IDX_ERR, 8'h00);
    rd(`IRQFS_IDX_FIFO1, 8'h00);
    rd(`IRQFS_IDX_FIFO2, 8'h00);
    // every-timeout option on, so the wake source shows in the sweep
    acc(1'b1, `IRQFS_IDX_CFG, 8'h01);
    // every source alone, then the read clears it
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i, 8'h00);
      check({7'h00, irq}, 8'h01);
      rd(`IRQFS_IDX_TIM, 8'h01 << i);
      rd(`IRQFS_IDX_TIM, 8'h00);
      pulse(8'h00, 8'h01 << i);
      rd(`IRQFS_IDX_ERR, 8'h01 << i);
      rd(`IRQFS_IDX_ERR, 8'h00);
    end
    // summary bit lives until the detailed read; mask hides the source
    pulse(8'h80, 8'h00);
    rd(`IRQFS_IDX_MAIN, 8'h02);
    rd(`IRQFS_IDX_MAIN, 8'h02);
    rd(`IRQFS_IDX_TIM, 8'h80);
    rd(`IRQFS_IDX_MAIN, 8'h00);
    acc(1'b1, `IRQFS_IDX_MASK_ERR, 8'hFF);
    pulse(8'h00, 8'h01);
    check({7'h00, irq}, 8'h00);
    rd(`IRQFS_IDX_MAIN, 8'h00);
    rd(`IRQFS_IDX_ERR, 8'h01);
    // set default wipes flags, masks and option
    acc(1'b1, `IRQFS_IDX_CFG, 8'h01);
    check({7'h00, wake_every}, 8'h01);
    pulse(8'h04, 8'h08);
    set_default <= 1'b1;
    @(posedge mclk_i);
    set_default <= 1'b0;
    @(posedge mclk_i);
    rd(`IRQFS_IDX_TIM, 8'h00);
    rd(`IRQFS_IDX_ERR, 8'h00);
    rd(`IRQFS_IDX_MASK_ERR, 8'h00);
    // one-shot mode after set default: a wake timeout stays silent
    check({7'h00, wake_every}, 8'h00);
    pulse(8'h00, 8'h08);
    rd(`IRQFS_IDX_ERR, 8'h00);
    // read-only write ignored, unmapped place refused
    acc(1'b1, `IRQFS_IDX_FIFO1, 8'hFF);
    rd(`IRQFS_IDX_FIFO1, 8'h00);
    rd(10'h3F0, 8'h00);
    check({7'h00, err}, 8'h01);
    // event in the access cycle of a clearing read survives
    fork
      rd(`IRQFS_IDX_TIM, 8'h00);
      begin
        @(posedge mclk_i);
        tev <= 8'h40;
        @(posedge mclk_i);
        tev <= 8'h00;
      end
    join
    rd(`IRQFS_IDX_TIM, 8'h40);
    // full fifo with a short last byte lacking parity
    cnt <= 7'h60;
    ncp <= 1'b1;
    lbits <= 3'h5;
    np <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(`IRQFS_IDX_FIFO1, 8'h60);
    rd(`IRQFS_IDX_FIFO2, 8'h1B);
    rd(`IRQFS_IDX_ERR, 8'h20);
    unf <= 1'b1;
    ovr <= 1'b1;
    @(posedge mclk_i);
    unf <= 1'b0;
    ovr <= 1'b0;
    cnt <= 7'h00;
    np <= 1'b0;
    lbits <= 3'h7;
    repeat (2) @(posedge mclk_i);
    rd(`IRQFS_IDX_FIFO1, 8'h00);
    rd(`IRQFS_IDX_FIFO2, 8'h60);
    fifo_clear <= 1'b1;
    @(posedge mclk_i);
    fifo_clear <= 1'b0;
    @(posedge mclk_i);
    rd(`IRQFS_IDX_FIFO2, 8'h00);
    end_of_test();
  end
endmodule
